//--- rtl/trp_reconfig_port.sv
// Reconfiguration access port for transceiver channels 8 to 11, with lane rx controls.
// Assumes controller logic on ref_clk, one outstanding access per channel.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Done pulses after read or write, with read data
// - Sixteen-bit read data valid with done
// - Freeze bit holds lane recovery loop state
// - Invert bit swaps lane receive polarity
module trp_reconfig_port
    import trp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Channel 8
    input wire logic ch8_access_strobe,
    input wire logic ch8_write_select,
    input wire logic [TRP_ADDR_W-1:0] ch8_cfg_addr,
    input wire logic [TRP_DATA_W-1:0] ch8_cfg_wdata,
    output logic [TRP_DATA_W-1:0] ch8_cfg_rdata,
    output logic ch8_cfg_done,
    // Channel 9
    input wire logic ch9_access_strobe,
    input wire logic ch9_write_select,
    input wire logic [TRP_ADDR_W-1:0] ch9_cfg_addr,
    input wire logic [TRP_DATA_W-1:0] ch9_cfg_wdata,
    output logic [TRP_DATA_W-1:0] ch9_cfg_rdata,
    output logic ch9_cfg_done,
    // Channel 10
    input wire logic ch10_access_strobe,
    input wire logic ch10_write_select,
    input wire logic [TRP_ADDR_W-1:0] ch10_cfg_addr,
    input wire logic [TRP_DATA_W-1:0] ch10_cfg_wdata,
    output logic [TRP_DATA_W-1:0] ch10_cfg_rdata,
    output logic ch10_cfg_done,
    // Channel 11
    input wire logic ch11_access_strobe,
    input wire logic ch11_write_select,
    input wire logic [TRP_ADDR_W-1:0] ch11_cfg_addr,
    input wire logic [TRP_DATA_W-1:0] ch11_cfg_wdata,
    output logic [TRP_DATA_W-1:0] ch11_cfg_rdata,
    output logic ch11_cfg_done,
    // Per-lane receive controls
    input wire logic [TRP_LANES-1:0] eye_scan_trigger,
    input wire logic [TRP_LANES-1:0] recovery_loop_freeze,
    input wire logic [TRP_LANES-1:0] rx_invert,
    input wire logic [TRP_LANES-1:0] rx_lane_data,
    // Per-lane results
    output logic [TRP_LANES-1:0] rx_lane_out,
    output logic [TRP_LANES-1:0] eye_scan_event,
    output logic [TRP_LANES-1:0] cdr_phase_lsb
);
    localparam int NCH = 4;

    logic [NCH-1:0] strobe;
    logic [NCH-1:0] wsel;
    logic [TRP_ADDR_W-1:0] addr [NCH];
    logic [TRP_DATA_W-1:0] wdata [NCH];
    logic [TRP_DATA_W-1:0] rdata_ff [NCH];
    logic [TRP_DATA_W-1:0] mem_rdata [NCH];
    logic [NCH-1:0] done_ff;

    assign strobe = {ch11_access_strobe, ch10_access_strobe, ch9_access_strobe,
        ch8_access_strobe};
    assign wsel = {ch11_write_select, ch10_write_select, ch9_write_select,
        ch8_write_select};
    assign addr[0] = ch8_cfg_addr;
    assign addr[1] = ch9_cfg_addr;
    assign addr[2] = ch10_cfg_addr;
    assign addr[3] = ch11_cfg_addr;
    assign wdata[0] = ch8_cfg_wdata;
    assign wdata[1] = ch9_cfg_wdata;
    assign wdata[2] = ch10_cfg_wdata;
    assign wdata[3] = ch11_cfg_wdata;

    genvar c;
    generate
        for (c = 0; c < NCH; c++)
        begin : g_ch
            trp_state_t state_ff;
            trp_state_t nxt_state;
            logic nxt_done;
            logic [TRP_DATA_W-1:0] nxt_rdata;
            logic mem_we;

            // Strobe low starts nothing; only idle accepts, so a strobe during an access is dropped
            assign mem_we = strobe[c] && wsel[c] &&
                (state_ff == TRP_IDLE);

            trp_cfg_mem u_mem (
                .ref_clk(ref_clk),
                .wr_en(mem_we),
                .addr(addr[c]),
                .wdata(wdata[c]),
                .rdata_ff(mem_rdata[c])
            );

            always_comb
            begin
                nxt_state = state_ff;
                nxt_done = 1'b0;
                nxt_rdata = rdata_ff[c];
                unique case (state_ff)
                    TRP_IDLE:
                    begin
                        if (strobe[c])
                        begin
                            nxt_state = wsel[c] ? TRP_WRITE : TRP_READ;
                        end
                    end
                    TRP_READ:
                    begin
                        nxt_done = 1'b1;
                        nxt_rdata = mem_rdata[c];
                        nxt_state = TRP_IDLE;
                    end
                    TRP_WRITE:
                    begin
                        nxt_done = 1'b1;
                        nxt_state = TRP_IDLE;
                    end
                    default:
                    begin
                        nxt_state = TRP_IDLE;
                    end
                endcase
            end

            always_ff @(posedge ref_clk)
            begin
                if (rst)
                begin
                    state_ff <= TRP_IDLE;
                    done_ff[c] <= 1'b0;
                    rdata_ff[c] <= TRP_DATA_RST;
                end
                else
                begin
                    state_ff <= nxt_state;
                    done_ff[c] <= nxt_done;
                    rdata_ff[c] <= nxt_rdata;
                end
            end
        end
    endgenerate

    assign ch8_cfg_rdata = rdata_ff[0];
    assign ch9_cfg_rdata = rdata_ff[1];
    assign ch10_cfg_rdata = rdata_ff[2];
    assign ch11_cfg_rdata = rdata_ff[3];
    assign ch8_cfg_done = done_ff[0];
    assign ch9_cfg_done = done_ff[1];
    assign ch10_cfg_done = done_ff[2];
    assign ch11_cfg_done = done_ff[3];

    // Lane receive path: a stand-in recovery loop is a phase counter per lane
    logic [TRP_LANES-1:0] rx_out_ff;
    logic [TRP_LANES-1:0] trig_prev_ff;
    logic [TRP_LANES-1:0] scan_ev_ff;
    logic [TRP_LANES-1:0] phase_lsb;

    genvar l;
    generate
        for (l = 0; l < TRP_LANES; l++)
        begin : g_lane
            logic [3:0] phase_ff;
            logic [3:0] nxt_phase;

            always_comb
            begin
                // Freeze keeps the loop exactly where it was
                nxt_phase = recovery_loop_freeze[l] ? phase_ff :
                    phase_ff + TRP_FREEZE_ADJ;
            end

            always_ff @(posedge ref_clk)
            begin
                if (rst)
                begin
                    phase_ff <= TRP_HIST_RST;
                end
                else
                begin
                    phase_ff <= nxt_phase;
                end
            end

            assign phase_lsb[l] = phase_ff[0];
        end
    endgenerate

    logic [TRP_LANES-1:0] nxt_rx_out;
    logic [TRP_LANES-1:0] nxt_scan_ev;

    always_comb
    begin
        nxt_rx_out = rx_lane_data ^ rx_invert;
        // Rising edge only, so a held trigger fires once
        nxt_scan_ev = eye_scan_trigger & ~trig_prev_ff;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rx_out_ff <= TRP_LANE_RST;
            trig_prev_ff <= TRP_LANE_RST;
            scan_ev_ff <= TRP_LANE_RST;
        end
        else
        begin
            rx_out_ff <= nxt_rx_out;
            trig_prev_ff <= eye_scan_trigger;
            scan_ev_ff <= nxt_scan_ev;
        end
    end

    assign rx_lane_out = rx_out_ff;
    assign eye_scan_event = scan_ev_ff;
    assign cdr_phase_lsb = phase_lsb;
endmodule // trp_reconfig_port
`default_nettype wire

//--- rtl/trp_pkg.sv
// Constants and types for the transceiver reconfiguration port block.
// Assumes a single reconfiguration clock domain for all lanes.
package trp_pkg;
    localparam int TRP_LANES = 12;
    localparam int TRP_ADDR_W = 10;
    localparam int TRP_DATA_W = 16;
    localparam int TRP_CFG_DEPTH = 1024;
    // Read latency of the config memory, in clock cycles, is one
    localparam logic [TRP_DATA_W-1:0] TRP_DATA_RST = 16'h0000;
    localparam logic [TRP_LANES-1:0] TRP_LANE_RST = 12'h000;
    localparam logic [3:0] TRP_HIST_RST = 4'h0;
    localparam logic [7:0] TRP_CNT_RST = 8'h00;
    localparam logic [7:0] TRP_CNT_ONE = 8'h01;
    localparam logic [3:0] TRP_FREEZE_ADJ = 4'h1;
    localparam logic [2:0] TRP_TAP_MSB = 3'h3;
    typedef enum logic [1:0] {TRP_IDLE, TRP_READ, TRP_WRITE} trp_state_t;
endpackage : trp_pkg

//--- rtl/trp_cfg_mem.sv
// One channel's configuration space: synchronous write, registered read.
// Assumes the caller issues at most one access per cycle.
`timescale 1ns/1ps
`default_nettype none
module trp_cfg_mem
    import trp_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Access
    input wire logic wr_en,
    input wire logic [TRP_ADDR_W-1:0] addr,
    input wire logic [TRP_DATA_W-1:0] wdata,
    output logic [TRP_DATA_W-1:0] rdata_ff
);
    logic [TRP_DATA_W-1:0] mem [TRP_CFG_DEPTH];

    // No reset on the array so it maps onto block memory
    always_ff @(posedge ref_clk)
    begin
        if (wr_en)
        begin
            mem[addr] <= wdata;
        end
        rdata_ff <= mem[addr];
    end
endmodule // trp_cfg_mem
`default_nettype wire

//--- tb/trp_reconfig_port_props.sv
// Checker: pin-level properties of the reconfiguration port.
// Assumes one ref_clk domain; bound from the testbench top.
`timescale 1ns/1ps
`default_nettype none
module trp_reconfig_port_props
    import trp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Config port
    input wire logic ch8_access_strobe,
    input wire logic ch8_cfg_done,
    input wire logic ch9_cfg_done,
    input wire logic [TRP_DATA_W-1:0] ch9_cfg_rdata,
    // Lanes
    input wire logic [TRP_LANES-1:0] recovery_loop_freeze,
    input wire logic [TRP_LANES-1:0] rx_invert,
    input wire logic [TRP_LANES-1:0] rx_lane_data,
    input wire logic [TRP_LANES-1:0] rx_lane_out,
    input wire logic [TRP_LANES-1:0] cdr_phase_lsb
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_done_latency: assert property ($rose(ch8_access_strobe) |-> ##2 ch8_cfg_done)
        else $error("done late");
    a_done_cause: assert property (ch8_cfg_done |-> $past(ch8_access_strobe, 2))
        else $error("done without access");
    a_rdata_hold: assert property ($changed(ch9_cfg_rdata) |-> ch9_cfg_done)
        else $error("read data moved");
    // Guarded: the first edge after release still sees reset values
    a_freeze_hold: assert property (!$past(rst) |->
        (cdr_phase_lsb ^ $past(cdr_phase_lsb)) == ~$past(recovery_loop_freeze))
        else $error("phase vs freeze");
    a_rx_invert: assert property (!$past(rst) |-> rx_lane_out ==
        ($past(rx_lane_data) ^ $past(rx_invert))) else $error("lane polarity");
endmodule // trp_reconfig_port_props
`default_nettype wire

//--- tb/trp_ctrl_model.sv
// Partner: controller logic doing reads and writes on channels 8 to 11.
// Assumes calls start just after a rising ref_clk edge, one at a time.
`timescale 1ns/1ps
`default_nettype none
module trp_ctrl_model
    import trp_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Requests, index 0 is channel 8
    output logic [3:0] stb,
    output logic [3:0] wsel,
    output logic [3:0][TRP_ADDR_W-1:0] addr,
    output logic [3:0][TRP_DATA_W-1:0] wdata,
    // Answers
    input wire logic [3:0] done,
    input wire logic [3:0][TRP_DATA_W-1:0] rdata
);
    initial
    begin
        stb = '0;
        wsel = '0;
        addr = '0;
        wdata = '0;
    end
    // Static task: calls never overlap; waits at most nine edges
    task xfer(input int c, input logic w, input logic [TRP_ADDR_W-1:0] a,
        input logic [TRP_DATA_W-1:0] d, output logic [TRP_DATA_W-1:0] q, output int n);
        stb[c] <= 1'b1;
        wsel[c] <= w;
        addr[c] <= a;
        wdata[c] <= d;
        @(posedge ref_clk);
        stb[c] <= 1'b0;
        wsel[c] <= ~w;
        wdata[c] <= ~d;
        for (n = 1; n < 9 && done[c] !== 1'b1; n++)
            @(posedge ref_clk);
        // Address held until done; the next call moves it
        q = rdata[c];
    endtask
endmodule // trp_ctrl_model
`default_nettype wire

//--- tb/trp_reconfig_port_tb.sv
// Testbench: config accesses on four channels and lane controls.
// Assumes the partner model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module trp_reconfig_port_tb
    import trp_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] stb, wsel, done;
    logic [3:0][TRP_ADDR_W-1:0] addr;
    logic [3:0][TRP_DATA_W-1:0] wdata, rdata;
    logic [TRP_LANES-1:0] trig = '0, frz = '0, inv = '0, din = '0, dout, evt, ph;
    logic [TRP_DATA_W-1:0] q;
    int n;
    int bad_count = 0;
    int total_checks = 0;
    always #25 ref_clk = ~ref_clk;
    trp_ctrl_model u_ctrl (.ref_clk, .stb, .wsel, .addr, .wdata, .done, .rdata);
    trp_reconfig_port u_dut (.ref_clk, .rst,
        .ch8_access_strobe(stb[0]), .ch8_write_select(wsel[0]), .ch8_cfg_addr(addr[0]),
        .ch8_cfg_wdata(wdata[0]), .ch8_cfg_rdata(rdata[0]), .ch8_cfg_done(done[0]),
        .ch9_access_strobe(stb[1]), .ch9_write_select(wsel[1]), .ch9_cfg_addr(addr[1]),
        .ch9_cfg_wdata(wdata[1]), .ch9_cfg_rdata(rdata[1]), .ch9_cfg_done(done[1]),
        .ch10_access_strobe(stb[2]), .ch10_write_select(wsel[2]), .ch10_cfg_addr(addr[2]),
        .ch10_cfg_wdata(wdata[2]), .ch10_cfg_rdata(rdata[2]), .ch10_cfg_done(done[2]),
        .ch11_access_strobe(stb[3]), .ch11_write_select(wsel[3]), .ch11_cfg_addr(addr[3]),
        .ch11_cfg_wdata(wdata[3]), .ch11_cfg_rdata(rdata[3]), .ch11_cfg_done(done[3]),
        .eye_scan_trigger(trig), .recovery_loop_freeze(frz), .rx_invert(inv),
        .rx_lane_data(din), .rx_lane_out(dout), .eye_scan_event(evt), .cdr_phase_lsb(ph));
    task chk(input string s, input logic [63:0] g, input logic [63:0] e);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task t_reset;
        chk("done", done, 4'h0);
        chk("rdata", rdata, '0);
        chk("lane_out", dout, '0);
        chk("eye_evt", evt, 12'h000);
        chk("phase", ph, 12'h000);
    endtask
    // Both address ends, write then read back, on every channel
    task t_cfg;
        for (int c = 0; c < 4; c++)
        begin
            u_ctrl.xfer(c, 1'b1, 10'h000, 16'h5a0f ^ 16'(c), q, n);
            chk("wr_lat", n, 3);
            u_ctrl.xfer(c, 1'b1, 10'h3ff, 16'hc3f0 ^ 16'(c), q, n);
            u_ctrl.xfer(c, 1'b0, 10'h000, 16'h0000, q, n);
            chk("rd_lat", n, 3);
            chk("rd_lo", q, 16'h5a0f ^ 16'(c));
            u_ctrl.xfer(c, 1'b0, 10'h3ff, 16'h0000, q, n);
            chk("rd_hi", q, 16'hc3f0 ^ 16'(c));
            // Read of 000 left write select high with strobe low: no write
            u_ctrl.xfer(c, 1'b0, 10'h000, 16'h0000, q, n);
            chk("rd_keep", q, 16'h5a0f ^ 16'(c));
        end
    endtask
    task t_lane;
        logic [TRP_LANES-1:0] p, x, prev;
        prev = '0;
        for (int i = 0; i < 4; i++)
        begin
            p = 12'h5a3 << i;
            din <= p;
            inv <= p ^ (12'h0f0 << i);
            frz <= p;
            trig <= p;
            repeat (2) @(posedge ref_clk);
            chk("lane_out", dout, 12'h0f0 << i);
            chk("eye_evt", evt, p & ~prev);
            x = ph;
            @(posedge ref_clk);
            chk("phase", ph ^ x, 12'(~p));
            chk("eye_pulse", evt, 12'h000);
            prev = p;
        end
    endtask
    initial
    begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset;
        @(posedge ref_clk);
        t_cfg;
        t_lane;
        final_report;
    end
    // Whole run needs about a hundred cycles
    initial
    begin
        repeat (2000) @(posedge ref_clk);
        bad_count++;
        final_report;
    end
endmodule // trp_reconfig_port_tb
bind trp_reconfig_port trp_reconfig_port_props u_props (.ref_clk, .rst, .ch8_access_strobe,
    .ch8_cfg_done, .ch9_cfg_done, .ch9_cfg_rdata, .recovery_loop_freeze, .rx_invert,
    .rx_lane_data, .rx_lane_out, .cdr_phase_lsb);
`default_nettype wire
